//--- include/dtx_regs.vh
// Register addresses, bit positions and reset values of the timer control block
`ifndef DTX_REGS_VH
`define DTX_REGS_VH

// ==========================================================
// Register addresses
`define DTX_ADDR_W        8
`define DTX_ADDR_RUNFLAGS 8'h88
`define DTX_ADDR_MODESEL  8'h89

// ==========================================================
// Run and flag register bits
`define DTX_BIT_OVF1      7
`define DTX_BIT_RUN1      6
`define DTX_BIT_OVF0      5
`define DTX_BIT_RUN0      4
`define DTX_BIT_DET1      3
`define DTX_BIT_TYPE1     2
`define DTX_BIT_DET0      1
`define DTX_BIT_TYPE0     0

// ==========================================================
// Mode register field positions within one nibble
`define DTX_MODE_GATE     3
`define DTX_MODE_CT       2
`define DTX_MODE_SELHI    1
`define DTX_MODE_SELLO    0
`define DTX_NIB_ONE       4
`define DTX_NIB_ZERO      0

// ==========================================================
// Reset values and unmapped answer
`define DTX_RST_RUNFLAGS  8'h00
`define DTX_RST_MODESEL   8'h00
`define DTX_UNMAPPED      8'hff

`endif

//--- verilog/dtx_chan.v
// One channel: pin synchronisers, edge detection and count enable
`timescale 1ns/10ps
`include "dtx_regs.vh"

module dtx_chan (
    // Clock and reset
    input  wire       clk_in,
    input  wire       rst_in,
    // Raw pins
    input  wire       irq_pin_in,
    input  wire       cnt_pin_in,
    // Controls
    input  wire       run_in,
    input  wire [3:0] mode_in,
    // Results
    output reg        irq_fall_out,
    output reg        irq_low_out,
    output reg        count_en_out
);

    // ==========================================================
    // Synchronisers: first stage read only by second stage
    reg irq_s1;
    reg irq_s2;
    reg irq_s3;
    reg cnt_s1;
    reg cnt_s2;
    reg cnt_s3;
    wire gate_ok;
    wire tick;

    always @(posedge clk_in) begin
        if (rst_in) begin
            irq_s1 <= 1'b1;
            irq_s2 <= 1'b1;
            irq_s3 <= 1'b1;
            cnt_s1 <= 1'b1;
            cnt_s2 <= 1'b1;
            cnt_s3 <= 1'b1;
        end else begin
            irq_s1 <= irq_pin_in;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
            cnt_s1 <= cnt_pin_in;
            cnt_s2 <= cnt_s1;
            cnt_s3 <= cnt_s2;
        end
    end

    // Gate passes only while pin high when gating set
    assign gate_ok = ~mode_in[`DTX_MODE_GATE] | irq_s2;
    // Internal clock or falling edge on count pin
    assign tick = mode_in[`DTX_MODE_CT] ? (cnt_s3 & ~cnt_s2) : 1'b1;

    // ==========================================================
    // Registered outputs
    always @(posedge clk_in) begin
        if (rst_in) begin
            irq_fall_out <= 1'b0;
            irq_low_out  <= 1'b0;
            count_en_out <= 1'b0;
        end else begin
            irq_fall_out <= irq_s3 & ~irq_s2;
            irq_low_out  <= ~irq_s2;
            count_en_out <= run_in & gate_ok & tick;
        end
    end

endmodule

//--- verilog/dtx_top.v
// Timer run control, overflow and external interrupt flag logic
`timescale 1ns/10ps
`include "dtx_regs.vh"
// Summary of operation
// - Timer one overflow sets bit 7; ack/software clear
// - Timer zero overflow sets bit 5; ack/software clear
// - Bit 6 starts and stops timer one
// - Bit 4 starts and stops timer zero
// - Ext one flag bit 3, edge or level
// - Ext zero flag bit 1, edge or level
// - Bit 2 picks ext one trigger type
// - Bit 0 picks ext zero trigger type
// - Gating: each timer needs its ext pin high
// - Select bit: internal clock or count pin
// - Bits 5,4 are timer one mode

module dtx_top (
    // Clock and reset
    input  wire       clk_in,
    input  wire       rst_in,
    // Register port
    input  wire [7:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       wr_in,
    input  wire       rd_in,
    output reg  [7:0] rdata_out,
    // Pins
    input  wire       ext_irq_one_pin_in,
    input  wire       ext_irq_zero_pin_in,
    input  wire       count_pin_one_in,
    input  wire       count_pin_zero_in,
    // Counting datapath events
    input  wire       overflow_one_in,
    input  wire       overflow_zero_in,
    input  wire       isr_ack_timer_one_in,
    input  wire       isr_ack_timer_zero_in,
    input  wire       isr_ack_ext_one_in,
    input  wire       isr_ack_ext_zero_in,
    // Status and controls
    output reg        count_en_one_out,
    output reg        count_en_zero_out,
    output reg  [1:0] mode_one_out,
    output reg  [1:0] mode_zero_out,
    output reg        overflow_flag_timer_one_out,
    output reg        overflow_flag_timer_zero_out,
    output reg        detect_flag_ext_one_out,
    output reg        detect_flag_ext_zero_out
);

    // ==========================================================
    // Register state
    reg  [7:0] timer_run_and_irq_flags;
    reg  [7:0] timer_mode_select;
    reg  [7:0] next_flags;
    wire       wr_flags;
    wire       wr_mode;
    wire       fall_one;
    wire       fall_zero;
    wire       low_one;
    wire       low_zero;
    wire       en_one;
    wire       en_zero;

    assign wr_flags = wr_in & (addr_in == `DTX_ADDR_RUNFLAGS);
    assign wr_mode  = wr_in & (addr_in == `DTX_ADDR_MODESEL);

    // Sticky flag update: hardware set beats any clear
    function flag_next;
        input cur;
        input sw_wr;
        input sw_val;
        input hw_clr;
        input hw_set;
        begin
            if (hw_set)
                flag_next = 1'b1;
            else if (sw_wr)
                flag_next = sw_val;
            else if (hw_clr)
                flag_next = 1'b0;
            else
                flag_next = cur;
        end
    endfunction

    // External flag: level mode follows pin, edge mode is sticky
    function ext_next;
        input cur;
        input type_edge;
        input sw_wr;
        input sw_val;
        input ack;
        input fall;
        input low;
        begin
            if (!type_edge)
                ext_next = low;
            else
                ext_next = flag_next(cur, sw_wr, sw_val, ack, fall);
        end
    endfunction

    // ==========================================================
    // Channel instances
    dtx_chan u_one (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .irq_pin_in   (ext_irq_one_pin_in),
        .cnt_pin_in   (count_pin_one_in),
        .run_in       (timer_run_and_irq_flags[`DTX_BIT_RUN1]),
        .mode_in      (timer_mode_select[`DTX_NIB_ONE+3:`DTX_NIB_ONE]),
        .irq_fall_out (fall_one),
        .irq_low_out  (low_one),
        .count_en_out (en_one)
    );

    dtx_chan u_zero (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .irq_pin_in   (ext_irq_zero_pin_in),
        .cnt_pin_in   (count_pin_zero_in),
        .run_in       (timer_run_and_irq_flags[`DTX_BIT_RUN0]),
        .mode_in      (timer_mode_select[`DTX_NIB_ZERO+3:`DTX_NIB_ZERO]),
        .irq_fall_out (fall_zero),
        .irq_low_out  (low_zero),
        .count_en_out (en_zero)
    );

    // ==========================================================
    // Next value of the run and flag register
    always @* begin
        next_flags = timer_run_and_irq_flags;
        next_flags[`DTX_BIT_OVF1] = flag_next(timer_run_and_irq_flags[`DTX_BIT_OVF1],
            wr_flags, wdata_in[`DTX_BIT_OVF1], isr_ack_timer_one_in,
            overflow_one_in);
        next_flags[`DTX_BIT_OVF0] = flag_next(timer_run_and_irq_flags[`DTX_BIT_OVF0],
            wr_flags, wdata_in[`DTX_BIT_OVF0], isr_ack_timer_zero_in,
            overflow_zero_in);
        // Type bit one selects falling edge
        next_flags[`DTX_BIT_DET1] = ext_next(timer_run_and_irq_flags[`DTX_BIT_DET1],
            timer_run_and_irq_flags[`DTX_BIT_TYPE1], wr_flags,
            wdata_in[`DTX_BIT_DET1], isr_ack_ext_one_in, fall_one, low_one);
        next_flags[`DTX_BIT_DET0] = ext_next(timer_run_and_irq_flags[`DTX_BIT_DET0],
            timer_run_and_irq_flags[`DTX_BIT_TYPE0], wr_flags,
            wdata_in[`DTX_BIT_DET0], isr_ack_ext_zero_in, fall_zero, low_zero);
        if (wr_flags) begin
            next_flags[`DTX_BIT_RUN1]  = wdata_in[`DTX_BIT_RUN1];
            next_flags[`DTX_BIT_RUN0]  = wdata_in[`DTX_BIT_RUN0];
            next_flags[`DTX_BIT_TYPE1] = wdata_in[`DTX_BIT_TYPE1];
            next_flags[`DTX_BIT_TYPE0] = wdata_in[`DTX_BIT_TYPE0];
        end
    end

    // ==========================================================
    // Registers
    always @(posedge clk_in) begin
        if (rst_in) begin
            timer_run_and_irq_flags <= `DTX_RST_RUNFLAGS;
            timer_mode_select       <= `DTX_RST_MODESEL;
        end else begin
            timer_run_and_irq_flags <= next_flags;
            if (wr_mode)
                timer_mode_select <= wdata_in;
        end
    end

    // ==========================================================
    // Read port: data valid the cycle after the strobe only
    always @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `DTX_ADDR_RUNFLAGS: rdata_out <= timer_run_and_irq_flags;
                `DTX_ADDR_MODESEL:  rdata_out <= timer_mode_select;
                default:            rdata_out <= `DTX_UNMAPPED;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // ==========================================================
    // Registered outputs toward the counting datapath
    always @(posedge clk_in) begin
        if (rst_in) begin
            count_en_one_out             <= 1'b0;
            count_en_zero_out            <= 1'b0;
            mode_one_out                 <= 2'h0;
            mode_zero_out                <= 2'h0;
            overflow_flag_timer_one_out  <= 1'b0;
            overflow_flag_timer_zero_out <= 1'b0;
            detect_flag_ext_one_out      <= 1'b0;
            detect_flag_ext_zero_out     <= 1'b0;
        end else begin
            count_en_one_out  <= en_one;
            count_en_zero_out <= en_zero;
            mode_one_out      <= {timer_mode_select[`DTX_NIB_ONE+`DTX_MODE_SELHI],
                                  timer_mode_select[`DTX_NIB_ONE+`DTX_MODE_SELLO]};
            mode_zero_out     <= {timer_mode_select[`DTX_NIB_ZERO+`DTX_MODE_SELHI],
                                  timer_mode_select[`DTX_NIB_ZERO+`DTX_MODE_SELLO]};
            overflow_flag_timer_one_out  <= timer_run_and_irq_flags[`DTX_BIT_OVF1];
            overflow_flag_timer_zero_out <= timer_run_and_irq_flags[`DTX_BIT_OVF0];
            detect_flag_ext_one_out      <= timer_run_and_irq_flags[`DTX_BIT_DET1];
            detect_flag_ext_zero_out     <= timer_run_and_irq_flags[`DTX_BIT_DET0];
        end
    end

endmodule

//--- dv/dtx_pins.sv
// Pin model: interrupt and count pins seen by the block
`timescale 1ns/10ps
module dtx_pins (
    // Levels asked for by the bench
    input  wire [3:0] lvl_in,
    // Pins, idle high as with a pull-up
    output wire       irq_one_out,
    output wire       irq_zero_out,
    output wire       cnt_one_out,
    output wire       cnt_zero_out
);
    // Plain wires; the bench only ever asks for clean levels
    assign {cnt_one_out, cnt_zero_out, irq_one_out, irq_zero_out} = lvl_in;
endmodule

//--- dv/dtx_chk.sv
// Port checker for the timer control block
`timescale 1ns/10ps
module dtx_chk (
    input wire       clk_in, rst_in, wr_in, rd_in,
    input wire [7:0] addr_in, wdata_in, rdata_out,
    input wire       overflow_one_in, overflow_zero_in,
    input wire       isr_ack_timer_one_in, isr_ack_timer_zero_in,
    input wire       count_en_one_out, count_en_zero_out,
    input wire       overflow_flag_timer_one_out, overflow_flag_timer_zero_out,
    input wire       detect_flag_ext_one_out
);
    // ==========================================================
    // Shadow of the run bits; only software moves them
    logic run1, run0;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            run1 <= 1'b0;
            run0 <= 1'b0;
        end else if (wr_in && addr_in == 8'h88) begin
            run1 <= wdata_in[6];
            run0 <= wdata_in[4];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Flag output lags the register by one cycle
    AST_OVF1_SET: assert property (overflow_one_in |=> ##1 overflow_flag_timer_one_out)
        else $error("overflow one flag not set");
    AST_OVF0_SET: assert property (overflow_zero_in |=> ##1 overflow_flag_timer_zero_out)
        else $error("overflow zero flag not set");
    AST_OVF1_ACK: assert property (isr_ack_timer_one_in && !overflow_one_in && !wr_in
        |=> ##1 !overflow_flag_timer_one_out) else $error("overflow one flag not cleared");
    AST_OVF0_ACK: assert property (isr_ack_timer_zero_in && !overflow_zero_in && !wr_in
        |=> ##1 !overflow_flag_timer_zero_out) else $error("overflow zero flag not cleared");
    // Enable output trails the run bit by two flops (channel, then top)
    AST_RUN1: assert property (count_en_one_out |-> $past(run1, 2))
        else $error("timer one counts while stopped");
    AST_RUN0: assert property (count_en_zero_out |-> $past(run0, 2))
        else $error("timer zero counts while stopped");
    AST_MODE_RB: assert property ((wr_in && addr_in == 8'h89) ##1 (rd_in && addr_in == 8'h89)
        |=> rdata_out == $past(wdata_in, 2)) else $error("mode register read back wrong");
    AST_CTL_RB: assert property ((wr_in && addr_in == 8'h88) ##1 (rd_in && addr_in == 8'h88)
        |=> (rdata_out & 8'h55) == ($past(wdata_in, 2) & 8'h55))
        else $error("run or type bits read back wrong");
    cover property (overflow_one_in ##2 overflow_flag_timer_one_out);
    cover property (count_en_one_out && count_en_zero_out);
    cover property (detect_flag_ext_one_out);
endmodule
bind dtx_top dtx_chk u_dtx_chk (.*);

//--- dv/dtx_top_bench.sv
// Self-checking bench for the timer control block
`timescale 1ns/10ps
module dtx_top_bench;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic       wr = 1'b0, rd = 1'b0;
    logic [5:0] ev = 6'h00;
    logic [3:0] lvl = 4'hf;
    wire  [7:0] rdata;
    wire        p1, p0, c1, c0, e1, e0, f1, f0, d1, d0;
    wire  [1:0] m1, m0;
    int         n_fail = 0, n_compared = 0;
    // ==========================================================
    // Design, pin model, clock
    dtx_top u_dtx_top (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .ext_irq_one_pin_in(p1), .ext_irq_zero_pin_in(p0),
        .count_pin_one_in(c1), .count_pin_zero_in(c0),
        .overflow_one_in(ev[0]), .overflow_zero_in(ev[1]),
        .isr_ack_timer_one_in(ev[2]), .isr_ack_timer_zero_in(ev[3]),
        .isr_ack_ext_one_in(ev[4]), .isr_ack_ext_zero_in(ev[5]),
        .count_en_one_out(e1), .count_en_zero_out(e0), .mode_one_out(m1),
        .mode_zero_out(m0), .overflow_flag_timer_one_out(f1),
        .overflow_flag_timer_zero_out(f0), .detect_flag_ext_one_out(d1),
        .detect_flag_ext_zero_out(d0));
    dtx_pins u_dtx_pins (.lvl_in(lvl), .irq_one_out(p1), .irq_zero_out(p0),
        .cnt_one_out(c1), .cnt_zero_out(c0));
    initial forever #2 clk_in = ~clk_in;
    // Shared bus, wait and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Write then read the same register with no gap between strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk_in);
        ev <= m;
        @(posedge clk_in);
        ev <= 6'h00;
    endtask
    task automatic pins(input logic [3:0] v, input int n);
        @(posedge clk_in);
        lvl <= v;
        w(n);
    endtask
    // Reset values, unmapped answer, mode fields
    task automatic t_regs;
        rd_reg(8'h88, 8'h00);
        rd_reg(8'h89, 8'h00);
        rd_reg(8'h8a, 8'hff);
        wr_rd(8'h89, 8'ha5, 8'ha5);
        w(2);
        chk(8'({m1, m0}), 8'h09);
        wr_rd(8'h89, 8'h5a, 8'h5a);
        w(2);
        chk(8'({m1, m0}), 8'h06);
        $display("test regs done");
    endtask
    // Overflow set, acknowledge, software set and clear
    task automatic t_ovf;
        pulse(6'h03);
        w(2);
        chk(8'({f1, f0}), 8'h03);
        rd_reg(8'h88, 8'ha0);
        pulse(6'h0c);
        rd_reg(8'h88, 8'h00);
        wr_rd(8'h88, 8'ha0, 8'ha0);
        wr_rd(8'h88, 8'h00, 8'h00);
        wr_rd(8'h88, 8'h55, 8'h55);
        wr_rd(8'h88, 8'h00, 8'h00);
        $display("test ovf done");
    endtask
    // Edge mode is sticky until acknowledged; level mode follows the pin
    task automatic t_ext;
        wr_reg(8'h88, 8'h05);
        pins(4'hc, 8);
        chk(8'({d1, d0}), 8'h03);
        pins(4'hf, 8);
        chk(8'({d1, d0}), 8'h03);
        pulse(6'h30);
        w(3);
        chk(8'({d1, d0}), 8'h00);
        wr_reg(8'h88, 8'h00);
        pins(4'hc, 8);
        rd_reg(8'h88, 8'h0a);
        pins(4'hf, 8);
        chk(8'({d1, d0}), 8'h00);
        $display("test ext done");
    endtask
    // Run bits, gating by interrupt pins, counter mode edges
    task automatic t_run;
        int k1, k0;
        wr_reg(8'h89, 8'h00);
        wr_reg(8'h88, 8'h50);
        w(3);
        chk(8'({e1, e0}), 8'h03);
        wr_reg(8'h89, 8'h88);
        pins(4'hc, 8);
        chk(8'({e1, e0}), 8'h00);
        pins(4'hf, 8);
        chk(8'({e1, e0}), 8'h03);
        wr_reg(8'h88, 8'h10);
        w(3);
        chk(8'({e1, e0}), 8'h01);
        wr_reg(8'h89, 8'h44);
        wr_reg(8'h88, 8'h50);
        w(4);
        chk(8'({e1, e0}), 8'h00);
        pins(4'h3, 0);
        k1 = 0;
        k0 = 0;
        repeat (16) begin
            w(1);
            k1 += int'(e1 === 1'b1);
            k0 += int'(e0 === 1'b1);
        end
        chk(8'(k1 * 16 + k0), 8'h11);
        pins(4'hf, 2);
        wr_reg(8'h88, 8'h00);
        $display("test run done");
    endtask
    // Verdict
    task automatic final_report;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #40000;
        n_fail++;
        final_report;
    end
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs;
        t_ovf;
        t_ext;
        t_run;
        final_report;
    end
endmodule
